// ---- core/fci_cycle.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "fci_regs.svh"
module fci_cycle (
    // system
    input  wire logic        pclk,
    input  wire logic        presetn,
    // request
    input  wire logic        start,
    input  wire logic        rd,
    input  wire logic [20:0] addr,
    input  wire logic [15:0] wdata,
    output logic             done,
    output logic [15:0]      rdata,
    // flash pins
    output logic [20:0]      fl_addr,
    input  wire logic [15:0] fl_dq_in,
    output logic [15:0]      fl_dq_out,
    output logic             fl_dq_oe,
    output logic             fl_ce_n,
    output logic             fl_oe_n,
    output logic             fl_we_n
);
    import fci_pkg::*;

    localparam logic [2:0] WP_CYC  = 3'(`FCI_WP_CYC);
    localparam logic [2:0] ACC_CYC = 3'(`FCI_ACC_CYC);
    localparam fci_cyc_t CYC_RST = '{st: CS_IDLE, ce_n: 1'b1, oe_n: 1'b1,
                                     we_n: 1'b1, default: '0};

    fci_cyc_t r;
    fci_cyc_t next_r;

    always_comb begin
        next_r = r;
        next_r.s1 = fl_dq_in;
        next_r.s2 = r.s1;
        case (r.st)
            CS_IDLE: if (start) begin
                next_r.st   = CS_SETUP;
                next_r.rd   = rd;
                next_r.a    = addr;
                next_r.d    = wdata;
                next_r.ce_n = 1'b0;
                next_r.drv  = !rd;
            end
            CS_SETUP: begin
                next_r.st  = CS_STROBE;
                next_r.cnt = r.rd ? ACC_CYC : WP_CYC;
                if (r.rd) begin
                    next_r.oe_n = 1'b0;
                end else begin
                    next_r.we_n = 1'b0;
                end
            end
            CS_STROBE: if (r.cnt == 3'h1) begin
                if (r.rd) begin
                    // two more cycles let the pin synchroniser catch up
                    next_r.st  = CS_SYNC;
                    next_r.cnt = 3'h2;
                end else begin
                    next_r.we_n = 1'b1; // see RULE23
                    next_r.st   = CS_HOLD;
                end
            end else begin
                next_r.cnt = r.cnt - 3'h1;
            end
            CS_SYNC: if (r.cnt == 3'h1) begin
                next_r.rdata = r.s2;
                next_r.oe_n  = 1'b1;
                next_r.st    = CS_HOLD;
            end else begin
                next_r.cnt = r.cnt - 3'h1;
            end
            CS_HOLD: begin
                // chip select rises a cycle after the strobe, data held till then
                next_r.ce_n = 1'b1; // see RULE23
                next_r.drv  = 1'b0;
                next_r.st   = CS_IDLE;
            end
            default: next_r = CYC_RST;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= CYC_RST;
        end else begin
            r <= next_r;
        end
    end

    assign done      = (r.st == CS_HOLD);
    assign rdata     = r.rdata;
    assign fl_addr   = r.a;
    assign fl_dq_out = r.d;
    assign fl_dq_oe  = r.drv;
    assign fl_ce_n   = r.ce_n;
    assign fl_oe_n   = r.oe_n;
    assign fl_we_n   = r.we_n;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_NO_OE_WE: assert property (fl_oe_n || fl_we_n) // see RULE20
        else $error("output gate and write strobe low together");
    AST_WE_FIRST: assert property ($rose(fl_we_n) |-> !fl_ce_n ##1 fl_ce_n) // see RULE23
        else $error("chip select did not rise one cycle after strobe");
    AST_WE_WIDTH: assert property ($fell(fl_we_n) |-> (!fl_we_n && fl_dq_oe)[*2] ##1 fl_we_n) // see RULE23
        else $error("write strobe width or data drive wrong");
    AST_READ_HIZ: assert property (!fl_oe_n |-> !fl_dq_oe && !fl_ce_n) // see RULE20
        else $error("data driven during read");
endmodule : fci_cycle
`default_nettype wire

// ---- core/fci_host.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "fci_regs.svh"
module fci_host (
    // system
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // flash pins
    output logic [20:0]      fl_addr,
    input  wire logic [15:0] fl_dq_in,
    output logic [15:0]      fl_dq_out,
    output logic             fl_dq_oe,
    output logic             fl_ce_n,
    output logic             fl_oe_n,
    output logic             fl_we_n,
    output logic             fl_rst_n
);
    import fci_pkg::*;

    localparam fci_host_t HOST_RST = '{st: MS_IDLE, frst: `FCI_CTRL_RESET,
                                       default: '0};

    fci_host_t   r;
    fci_host_t   next_r;
    fci_step_t   stp;
    logic [15:0] page_mem [16];
    logic [3:0]  pidx;
    logic        cyc_start;
    logic        cyc_done;
    logic [15:0] cyc_rdata;
    logic        wr;
    logic        rdph;

    function automatic logic fci_mapped(input logic [7:0] a);
        return a inside {`FCI_OFF_CMD, `FCI_OFF_ADDR, `FCI_OFF_WDATA,
                         `FCI_OFF_COUNT, `FCI_OFF_PAGE, `FCI_OFF_STATUS,
                         `FCI_OFF_RDATA, `FCI_OFF_CTRL};
    endfunction : fci_mapped

    // refuses what the flash would reject or misread
    function automatic logic fci_legal(input fci_host_t h);
        logic ok;
        ok = (h.op <= `FCI_OP_PCFG);
        if (h.op == `FCI_OP_OTP) begin
            ok = (h.addr[20:16] == 5'h00) && (h.addr[15:0] >= `FCI_OTP_LO)
                 && (h.addr[15:0] <= `FCI_OTP_HI); // see RULE14
        end
        if (h.op == `FCI_OP_PAGE) begin
            ok = (h.count != 5'h00) && (h.count <= `FCI_PAGE_MAX);
        end
        return ok;
    endfunction : fci_legal

    // one flash bus cycle of an operation, chosen by its step number
    function automatic fci_step_t fci_step(input fci_host_t h,
                                           input logic [15:0] pw);
        fci_step_t  s;
        logic [15:0] c1;
        logic [15:0] c2;
        logic        two;
        logic        rd2;
        logic [3:0]  k;
        s   = '{rd: 1'b0, last: 1'b1, a: h.addr, d: 16'h0000}; // see RULE18
        c1  = 16'h0000;
        c2  = h.wdata;
        two = 1'b1;
        rd2 = 1'b1;
        k   = 4'(h.step - 5'h02);
        case (h.op)
            `FCI_OP_READ: begin
                two  = 1'b0;
                s.rd = 1'b1;
            end
            `FCI_OP_ARRAY: begin
                two = 1'b0;
                c1  = `FCI_CD_ARRAY; // see RULE1
            end
            `FCI_OP_ID: c1 = `FCI_CD_ID; // see RULE2
            `FCI_OP_QUERY: c1 = `FCI_CD_QUERY; // see RULE3
            `FCI_OP_STATUS: c1 = `FCI_CD_STATUS; // see RULE4
            `FCI_OP_CLRST: begin
                two = 1'b0;
                c1  = `FCI_CD_CLRST; // see RULE4
            end
            `FCI_OP_SUSP: begin
                two = 1'b0;
                c1  = `FCI_CD_SUSP; // see RULE8
            end
            `FCI_OP_RESUME: begin
                two = 1'b0;
                c1  = `FCI_CD_CONFIRM; // see RULE8
            end
            `FCI_OP_BERASE: begin
                rd2 = 1'b0;
                c1  = `FCI_CD_BERASE; // see RULE5
                c2  = `FCI_CD_CONFIRM;
            end
            `FCI_OP_CERASE: begin
                rd2 = 1'b0;
                c1  = `FCI_CD_CERASE; // see RULE5
                c2  = `FCI_CD_CONFIRM;
            end
            `FCI_OP_PROG: begin
                rd2 = 1'b0;
                c1  = h.alt ? `FCI_CD_PROG2 : `FCI_CD_PROG; // see RULE6
            end
            `FCI_OP_LOCK: begin
                rd2 = 1'b0;
                c1  = `FCI_CD_LOCKSU; // see RULE9
                c2  = `FCI_CD_LOCK;
            end
            `FCI_OP_UNLOCK: begin
                rd2 = 1'b0;
                c1  = `FCI_CD_LOCKSU; // see RULE9
                c2  = `FCI_CD_CONFIRM;
            end
            `FCI_OP_LOCKDN: begin
                rd2 = 1'b0;
                c1  = `FCI_CD_LOCKSU; // see RULE9
                c2  = `FCI_CD_LOCKDN;
            end
            `FCI_OP_OTP: begin
                rd2 = 1'b0;
                c1  = `FCI_CD_OTP; // see RULE14
            end
            `FCI_OP_PCFG: begin
                rd2 = 1'b0;
                c1  = `FCI_CD_LOCKSU; // see RULE10
                c2  = `FCI_CD_PCFG;
                s.a = {5'h00, h.wdata}; // see RULE10
            end
            default: two = 1'b0;
        endcase
        if (h.op == `FCI_OP_PAGE) begin
            if (h.step == 5'h00) begin
                s.d    = `FCI_CD_PAGE; // see RULE7
                s.last = 1'b0;
            end else if (h.step == 5'h01) begin
                s.d    = {11'h000, h.count - 5'h01}; // see RULE25
                s.last = 1'b0;
            end else if (h.step < h.count + 5'h02) begin
                s.d    = pw;
                s.a    = h.addr + 21'(k);
                s.last = 1'b0;
            end else begin
                s.d = `FCI_CD_CONFIRM; // see RULE7
            end
        end else if (two) begin
            // second cycle reuses the first cycle's address
            s.last = (h.step != 5'h00); // see RULE19
            s.d    = (h.step == 5'h00) ? c1 : c2;
            s.rd   = rd2 && (h.step != 5'h00);
        end else if (!s.rd) begin
            s.d = c1;
        end
        return s;
    endfunction : fci_step

    assign pidx = 4'(r.step - 5'h02);
    assign stp  = fci_step(r, page_mem[pidx]);
    assign wr   = psel && penable && pwrite;
    assign rdph = psel && !penable && !pwrite;

    always_comb begin
        fci_host_t cand;
        cand   = r;
        next_r = r;
        cand.op = pwdata[4:0];
        // register writes and status clears first, so hardware sets win
        if (wr) begin
            case (paddr)
                `FCI_OFF_ADDR: next_r.addr = pwdata[20:0];
                `FCI_OFF_WDATA: next_r.wdata = pwdata[15:0];
                `FCI_OFF_COUNT: begin
                    next_r.count = pwdata[4:0];
                    next_r.wptr  = 4'h0;
                end
                `FCI_OFF_PAGE: next_r.wptr = r.wptr + 4'h1;
                `FCI_OFF_CTRL: next_r.frst = pwdata[`FCI_CTRL_FRST];
                `FCI_OFF_STATUS: begin
                    if (pwdata[`FCI_ST_DONE]) begin
                        next_r.done = 1'b0;
                    end
                    if (pwdata[`FCI_ST_ERR]) begin
                        next_r.err = 1'b0;
                    end
                end
                `FCI_OFF_CMD: begin
                    // no queueing: a command while busy is refused
                    if (r.st != MS_IDLE || !fci_legal(cand)) begin
                        next_r.err = 1'b1;
                    end else begin
                        next_r.op   = pwdata[4:0];
                        next_r.alt  = pwdata[`FCI_CMD_ALT];
                        next_r.step = 5'h00;
                        next_r.st   = MS_RUN;
                    end
                end
                default: ;
            endcase
        end
        case (r.st)
            MS_IDLE: ;
            MS_RUN: next_r.st = MS_WAIT;
            MS_WAIT: if (cyc_done) begin
                if (stp.rd) begin
                    next_r.rdata = cyc_rdata;
                end
                if (stp.last) begin
                    next_r.st   = MS_IDLE;
                    next_r.done = 1'b1;
                end else begin
                    next_r.step = r.step + 5'h01;
                    next_r.st   = MS_RUN;
                end
            end
            default: next_r.st = MS_IDLE;
        endcase
        if (rdph) begin
            next_r.prdata = 32'h0000_0000;
            case (paddr)
                `FCI_OFF_CMD: next_r.prdata[8:0] = {r.alt, 3'h0, r.op};
                `FCI_OFF_ADDR: next_r.prdata[20:0] = r.addr;
                `FCI_OFF_WDATA: next_r.prdata[15:0] = r.wdata;
                `FCI_OFF_COUNT: next_r.prdata[4:0] = r.count;
                `FCI_OFF_PAGE: next_r.prdata[3:0] = r.wptr;
                `FCI_OFF_STATUS: begin
                    next_r.prdata[`FCI_ST_BUSY] = (r.st != MS_IDLE);
                    next_r.prdata[`FCI_ST_DONE] = r.done;
                    next_r.prdata[`FCI_ST_ERR]  = r.err;
                    next_r.prdata[`FCI_ST_FRST] = r.frst;
                end
                `FCI_OFF_RDATA: next_r.prdata[15:0] = r.rdata;
                `FCI_OFF_CTRL: next_r.prdata[`FCI_CTRL_FRST] = r.frst;
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= HOST_RST;
        end else begin
            r <= next_r;
        end
    end

    // page data needs no reset, software loads it before use
    always_ff @(posedge pclk) begin
        if (wr && paddr == `FCI_OFF_PAGE) begin
            page_mem[r.wptr] <= pwdata[15:0];
        end
    end

    assign cyc_start = (r.st == MS_RUN);
    assign prdata    = r.prdata;
    assign pready    = psel && penable;
    assign pslverr   = psel && penable && !fci_mapped(paddr);
    // flash comes out of reset in array read; no command is held back meanwhile
    assign fl_rst_n  = !r.frst; // see RULE24

    fci_cycle u_cycle (
        .pclk      (pclk),
        .presetn   (presetn),
        .start     (cyc_start),
        .rd        (stp.rd),
        .addr      (stp.a),
        .wdata     (stp.d),
        .done      (cyc_done),
        .rdata     (cyc_rdata),
        .fl_addr   (fl_addr),
        .fl_dq_in  (fl_dq_in),
        .fl_dq_out (fl_dq_out),
        .fl_dq_oe  (fl_dq_oe),
        .fl_ce_n   (fl_ce_n),
        .fl_oe_n   (fl_oe_n),
        .fl_we_n   (fl_we_n)
    );

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_ARRAY_ONE: assert property (cyc_start && r.op == `FCI_OP_ARRAY |-> // see RULE1
        stp.d == 16'h00ff && stp.last && !stp.rd)
        else $error("array read not a single ff write");
    AST_ID_READ: assert property (cyc_start && r.op == `FCI_OP_ID && r.step == 5'h00 |-> // see RULE2
        stp.d == 16'h0090 ##[3:8] (cyc_start && stp.rd && r.step == 5'h01))
        else $error("identifier command not followed by a read");
    AST_STATUS_READ: assert property (cyc_start && r.op == `FCI_OP_STATUS && r.step == 5'h01 |-> // see RULE4
        stp.rd && stp.a == r.addr && stp.last)
        else $error("status read misplaced");
    AST_CONFIRM: assert property (cyc_start && r.step == 5'h01 && // see RULE5
        (r.op == `FCI_OP_BERASE || r.op == `FCI_OP_CERASE) |-> stp.d == 16'h00d0 && !stp.rd)
        else $error("erase confirm not d0");
    AST_PROG_CODE: assert property (cyc_start && r.op == `FCI_OP_PROG && r.step == 5'h00 |-> // see RULE6
        stp.d == (r.alt ? 16'h0010 : 16'h0040))
        else $error("program setup code wrong");
    AST_PAGE_COUNT: assert property (cyc_start && r.op == `FCI_OP_PAGE && r.step == 5'h01 |-> // see RULE25
        stp.d[4:0] == r.count - 5'h01 && $past(stp.d, 5) == 16'h00e8)
        else $error("page count cycle wrong");
    AST_PAGE_END: assert property (cyc_start && r.op == `FCI_OP_PAGE && stp.last |-> // see RULE7
        stp.d == 16'h00d0 && r.step == r.count + 5'h02)
        else $error("page program not closed by confirm");
    AST_LOCK_SETUP: assert property (cyc_start && r.step == 5'h00 && // see RULE9
        r.op inside {`FCI_OP_LOCK, `FCI_OP_UNLOCK, `FCI_OP_LOCKDN} |-> stp.d == 16'h0060)
        else $error("lock setup not 60");
    AST_PCFG_ADDR: assert property (cyc_start && r.op == `FCI_OP_PCFG |-> // see RULE10
        stp.a[15:0] == r.wdata)
        else $error("config code not on address lines");
    AST_OTP_RANGE: assert property (cyc_start && r.op == `FCI_OP_OTP |-> // see RULE14
        stp.a[15:0] >= 16'h0080 && stp.a[15:0] <= 16'h0088)
        else $error("one-time program outside its area");
    AST_SAME_ADDR: assert property (cyc_start && r.step == 5'h01 && // see RULE19
        r.op inside {`FCI_OP_BERASE, `FCI_OP_PROG, `FCI_OP_LOCK, `FCI_OP_OTP}
        |-> stp.a == $past(stp.a, 5))
        else $error("second cycle address differs");
    AST_SUSPEND: assert property (cyc_start && r.op == `FCI_OP_SUSP |-> // see RULE8
        stp.d == 16'h00b0 ##[3:8] $rose(r.done))
        else $error("suspend not single b0 write");

    COV_PAGE: cover property (cyc_start && r.op == `FCI_OP_PAGE && stp.last);
    COV_ID: cover property (cyc_done && stp.rd && r.op == `FCI_OP_ID);
    COV_ERASE: cover property (cyc_start && r.op == `FCI_OP_BERASE && stp.last);
    COV_BUSY_REFUSE: cover property (wr && paddr == `FCI_OFF_CMD && r.st != MS_IDLE);
endmodule : fci_host
`default_nettype wire

// ---- core/fci_pkg.sv ----
`default_nettype none
package fci_pkg;
    typedef enum logic [2:0] {CS_IDLE, CS_SETUP, CS_STROBE, CS_SYNC, CS_HOLD} fci_cstate_t;
    typedef enum logic [1:0] {MS_IDLE, MS_RUN, MS_WAIT} fci_mstate_t;

    typedef struct packed {
        fci_cstate_t st;
        logic [2:0]  cnt;
        logic        rd;
        logic [20:0] a;
        logic [15:0] d;
        logic        drv;
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
        logic [15:0] s1;
        logic [15:0] s2;
        logic [15:0] rdata;
    } fci_cyc_t;

    typedef struct packed {
        logic        rd;
        logic        last;
        logic [20:0] a;
        logic [15:0] d;
    } fci_step_t;

    typedef struct packed {
        fci_mstate_t st;
        logic [4:0]  op;
        logic        alt;
        logic [20:0] addr;
        logic [15:0] wdata;
        logic [4:0]  count;
        logic [3:0]  wptr;
        logic [4:0]  step;
        logic        done;
        logic        err;
        logic        frst;
        logic [15:0] rdata;
        logic [31:0] prdata;
    } fci_host_t;
endpackage : fci_pkg
`default_nettype wire

// ---- core/fci_regs.svh ----
`ifndef FCI_REGS_SVH
`define FCI_REGS_SVH
// Operation
// RULE1 - one write of ffh to a partition returns it to array read
// RULE2 - 90h puts a partition into identifier and one-time area read
// RULE3 - 98h puts a partition into query read
// RULE4 - 70h makes the next read return status; 50h clears status
// RULE5 - block erase is 20h then d0h; chip erase is 30h then d0h
// RULE6 - word program setup is 40h or 10h, then the data word
// RULE7 - page program: e8h, word count, data words, four cycles or more
// RULE8 - b0h suspends erase or program, d0h resumes it
// RULE9 - 60h setup then 01h lock, d0h unlock, 2fh lock-down
// RULE10 - 60h then 04h load partition config, code on address lines
// RULE11 - identifier mode maps maker, device, config and one-time words
// RULE12 - block base plus 2 reads lock and lock-down flags
// RULE13 - identifier reads are relative to the partition given with 90h
// RULE14 - one-time area program only at words 80h to 88h
// RULE15 - only one partition erases or programs at a time
// RULE16 - each partition keeps its own status word
// RULE17 - other partitions are limited while one erases or programs
// RULE18 - each command goes to an address inside its target block
// RULE19 - both cycles of a two-cycle command carry the same address
// RULE20 - output gate and write strobe never low together
// RULE21 - at program voltage lockout reads work, erase and program refused
// RULE22 - parameter blocks from 0, main blocks above, four planes
// RULE23 - address and data latch on first rising chip select or strobe
// RULE24 - after reset every partition is in array read
// RULE25 - page program count cycle carries word count minus one

// timing, one pclk is 50 ns
`define FCI_CLK_NS    50
`define FCI_T_WP_NS   70
`define FCI_T_ACC_NS  90
`define FCI_WP_CYC    ((`FCI_T_WP_NS + `FCI_CLK_NS - 1) / `FCI_CLK_NS)
`define FCI_ACC_CYC   ((`FCI_T_ACC_NS + `FCI_CLK_NS - 1) / `FCI_CLK_NS)

// register offsets
`define FCI_OFF_CMD    8'h00
`define FCI_OFF_ADDR   8'h04
`define FCI_OFF_WDATA  8'h08
`define FCI_OFF_COUNT  8'h0c
`define FCI_OFF_PAGE   8'h10
`define FCI_OFF_STATUS 8'h14
`define FCI_OFF_RDATA  8'h18
`define FCI_OFF_CTRL   8'h1c

// field positions, reset values and limits
`define FCI_CMD_ALT    8
`define FCI_ST_BUSY    0
`define FCI_ST_DONE    1
`define FCI_ST_ERR     2
`define FCI_ST_FRST    3
`define FCI_CTRL_FRST  0
`define FCI_CTRL_RESET 1'b0
`define FCI_PAGE_MAX   5'h10
`define FCI_OTP_LO     16'h0080
`define FCI_OTP_HI     16'h0088

// operation codes of the command register
`define FCI_OP_READ    5'h00
`define FCI_OP_ARRAY   5'h01
`define FCI_OP_ID      5'h02
`define FCI_OP_QUERY   5'h03
`define FCI_OP_STATUS  5'h04
`define FCI_OP_CLRST   5'h05
`define FCI_OP_BERASE  5'h06
`define FCI_OP_CERASE  5'h07
`define FCI_OP_PROG    5'h08
`define FCI_OP_PAGE    5'h09
`define FCI_OP_SUSP    5'h0a
`define FCI_OP_RESUME  5'h0b
`define FCI_OP_LOCK    5'h0c
`define FCI_OP_UNLOCK  5'h0d
`define FCI_OP_LOCKDN  5'h0e
`define FCI_OP_OTP     5'h0f
`define FCI_OP_PCFG    5'h10

// flash command codes
`define FCI_CD_ARRAY   16'h00ff
`define FCI_CD_ID      16'h0090
`define FCI_CD_QUERY   16'h0098
`define FCI_CD_STATUS  16'h0070
`define FCI_CD_CLRST   16'h0050
`define FCI_CD_BERASE  16'h0020
`define FCI_CD_CERASE  16'h0030
`define FCI_CD_CONFIRM 16'h00d0
`define FCI_CD_PROG    16'h0040
`define FCI_CD_PROG2   16'h0010
`define FCI_CD_PAGE    16'h00e8
`define FCI_CD_SUSP    16'h00b0
`define FCI_CD_LOCKSU  16'h0060
`define FCI_CD_LOCK    16'h0001
`define FCI_CD_LOCKDN  16'h002f
`define FCI_CD_OTP     16'h00c0
`define FCI_CD_PCFG    16'h0004
`endif

// ---- verif/fci_flash_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module fci_flash_model #(
    parameter logic [15:0] MAKER = 16'h5a5a // arbitrary value
) (
    // flash pins
    input  wire logic [20:0] fl_addr,
    input  wire logic [15:0] fl_dq_out,
    input  wire logic        fl_ce_n,
    input  wire logic        fl_oe_n,
    input  wire logic        fl_we_n,
    input  wire logic        fl_rst_n,
    output logic [15:0]      fl_dq_in
);
    logic [36:0] wlog[$];
    logic [7:0]  mode  = 8'hff;
    logic        clash = 1'b0;
    logic [15:0] rd;
    logic        lockw;
    // lock word sits at base plus 2 of a small or a large block
    assign lockw = fl_addr[20:15] == 6'h00 ? fl_addr[11:0] == 12'h002
                 : fl_addr[14:0] == 15'h0002;
    always @(posedge fl_we_n or posedge fl_ce_n or negedge fl_rst_n)
        if (!fl_rst_n) mode = 8'hff;
        else if (fl_we_n ^ fl_ce_n) begin
            wlog.push_back({fl_addr, fl_dq_out});
            if (fl_dq_out inside {16'h00ff, 16'h0090, 16'h0098, 16'h0070})
                mode = fl_dq_out[7:0];
        end
    always @(negedge fl_oe_n or negedge fl_we_n)
        if (!fl_oe_n && !fl_we_n) clash = 1'b1;
    always_comb
        rd = mode == 8'h90 ? (fl_addr[15:0] == 16'h0000 ? MAKER
           : lockw ? 16'h0001 : 16'h0000)
           : mode == 8'h70 ? 16'h0080 : ~fl_addr[15:0];
    // deselected bus shows the inverse, not a stale value
    assign fl_dq_in = (!fl_ce_n && !fl_oe_n) ? rd : ~rd;
endmodule : fci_flash_model
`default_nettype wire

// ---- verif/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, perr;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rv, st;
    logic        pready, pslverr, dq_oe, ce_n, oe_n, we_n, rst_n;
    logic [20:0] fa;
    logic [15:0] dqi, dqo;
    int          fail_count = 0, checked = 0;
    logic [8:0]  ops[11] = '{1, 5, 6, 7, 8, 9'h108, 10, 11, 12, 13, 14};
    logic [15:0] c1[11] = '{16'h00ff, 16'h0050, 16'h0020, 16'h0030, 16'h0040, 16'h0010,
                           16'h00b0, 16'h00d0, 16'h0060, 16'h0060, 16'h0060};
    logic [15:0] c2[11] = '{0, 0, 16'h00d0, 16'h00d0, 16'h1234, 16'h1234, 0, 0,
                           16'h0001, 16'h00d0, 16'h002f};
    always #25 pclk = ~pclk;
    fci_host i_fci_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fl_addr(fa), .fl_dq_in(dqi), .fl_dq_out(dqo), .fl_dq_oe(dq_oe),
        .fl_ce_n(ce_n), .fl_oe_n(oe_n), .fl_we_n(we_n), .fl_rst_n(rst_n));
    fci_flash_model i_fci_flash_model (.fl_addr(fa), .fl_dq_out(dqo), .fl_ce_n(ce_n),
        .fl_oe_n(oe_n), .fl_we_n(we_n), .fl_rst_n(rst_n), .fl_dq_in(dqi));
    task automatic wrap_up;
        if (fail_count == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up
    task automatic check(input logic [47:0] s, input logic [47:0] e);
        checked++;
        if (s !== e) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : check
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        check(n < 20, 1);
        if (n == 20) wrap_up();
        rv = prdata;
        perr = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic run(input logic [8:0] cmd, input logic [20:0] a, input logic [15:0] d);
        int n;
        n = 0;
        i_fci_flash_model.wlog.delete();
        apb(1, 8'h04, 32'(a));
        apb(1, 8'h08, 32'(d));
        apb(1, 8'h00, 32'(cmd));
        do begin
            apb(0, 8'h14, 0);
            n++;
        end while (rv[2:1] == 2'b00 && n < 100);
        check(n < 100, 1);
        if (n == 100) wrap_up();
        st = rv;
        apb(1, 8'h14, 32'h0000_0006);
    endtask : run
    task automatic ex(input int k, input logic [20:0] a, input logic [15:0] d);
        check(i_fci_flash_model.wlog[k], {a, d});
    endtask : ex
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, 8'h14, 0);
        check({rv, ce_n, oe_n, we_n, rst_n}, 4'hf);
        apb(0, 8'h20, 0);
        check(perr, 1);
        for (int i = 0; i < 11; i++) begin
            run(ops[i], 21'h0_8002, 16'h1234);
            check(i_fci_flash_model.wlog.size(), (c2[i] != 0) + 1);
            ex(0, 21'h0_8002, c1[i]);
            if (c2[i] != 0) ex(1, 21'h0_8002, c2[i]);
        end
        run(0, 21'h0_0123, 0);
        apb(0, 8'h18, 0);
        check(rv, 32'h0000_fedc);
        run(2, 21'h0_0000, 0);
        ex(0, 21'h0_0000, 16'h0090);
        apb(0, 8'h18, 0);
        check(rv, 32'h0000_5a5a);
        run(2, 21'h0_8002, 0);
        apb(0, 8'h18, 0);
        check(rv, 32'h0000_0001);
        run(4, 21'h0_8000, 0);
        ex(0, 21'h0_8000, 16'h0070);
        apb(0, 8'h18, 0);
        check(rv, 32'h0000_0080);
        run(3, 21'h0_0010, 0);
        ex(0, 21'h0_0010, 16'h0098);
        run(15, 21'h0_0085, 16'h1111);
        ex(0, 21'h0_0085, 16'h00c0);
        ex(1, 21'h0_0085, 16'h1111);
        run(15, 21'h0_0090, 16'h1111);
        check({i_fci_flash_model.wlog.size(), st[2]}, 1);
        apb(1, 8'h0c, 2);
        apb(1, 8'h10, 32'h0000_aaaa);
        apb(1, 8'h10, 32'h0000_5555);
        run(9, 21'h0_0200, 0);
        check(i_fci_flash_model.wlog.size(), 5);
        ex(0, 21'h0_0200, 16'h00e8);
        ex(1, 21'h0_0200, 16'h0001);
        ex(2, 21'h0_0200, 16'haaaa);
        ex(3, 21'h0_0201, 16'h5555);
        ex(4, 21'h0_0200, 16'h00d0);
        run(16, 21'h0_0000, 16'h0123);
        ex(0, 21'h0_0123, 16'h0060);
        ex(1, 21'h0_0123, 16'h0004);
        apb(1, 8'h1c, 1);
        apb(0, 8'h14, 0);
        check({rv[3], rst_n, i_fci_flash_model.mode}, 10'h2ff);
        apb(1, 8'h1c, 0);
        apb(1, 8'h00, 6);
        apb(1, 8'h00, 7);
        apb(0, 8'h14, 0);
        check(rv[2:0], 3'b101);
        check(i_fci_flash_model.clash, 0);
        wrap_up();
    end
endmodule : tb
`default_nettype wire
